/* bench/fdw_monitor.sv */
// Concurrent checks on the serial link and the flash end's state outputs.
`timescale 1ns/1ps
module fdw_monitor #(
    parameter int unsigned POWERUP_CYCLES = fdw_pkg::POWERUP_CYC,
    parameter int unsigned CYCLE_CYCLES = fdw_pkg::CYCLE_TIME_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso_oe,
    input wire logic [7:0] status_byte,
    input wire logic in_deep_sleep,
    input wire logic accepting,
    input wire logic [7:0] array_fill
);
    localparam int SLEEP_MIN = fdw_pkg::SLEEP_ENTRY_CYC;
    localparam int WAKE_MIN = fdw_pkg::WAKE_CYC;
    localparam int SLACK = 16;

    // ==========================================================
    // Helper logic
    logic sclk_r;
    logic [5:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [7:0] first_byte_r;
    logic [15:0] hi_cnt_r;
    int up_cnt_r;
    int busy_cnt_r;
    logic slept_r;
    wire sclk_rise = sclk && !sclk_r;
    wire [7:0] shift_nxt = {shift_r[6:0], mosi};
    wire hi_full = hi_cnt_r == 16'hffff;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_r <= 1'b0;
            bit_cnt_r <= 6'h00;
            shift_r <= 8'h00;
            first_byte_r <= 8'h00;
            hi_cnt_r <= 16'h0000;
            up_cnt_r <= 0;
            busy_cnt_r <= 0;
            slept_r <= 1'b0;
        end else begin
            sclk_r <= sclk;
            bit_cnt_r <= cs_n ? 6'h00 : bit_cnt_r + {5'h00, sclk_rise};
            shift_r <= sclk_rise ? shift_nxt : shift_r;
            if (sclk_rise && bit_cnt_r == 6'h07) begin
                first_byte_r <= shift_nxt;
            end
            hi_cnt_r <= !cs_n ? 16'h0000 : hi_cnt_r + {15'h0000, !hi_full};
            if (up_cnt_r < int'(POWERUP_CYCLES)) begin
                up_cnt_r <= up_cnt_r + 1;
            end
            busy_cnt_r <= status_byte[0] ? busy_cnt_r + 1 : 0;
            slept_r <= in_deep_sleep | (slept_r & !accepting);
        end
    end

    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // ==========================================================
    // Assertions
    a_sleep_entry_time: assert property ($rose(in_deep_sleep) |->
        first_byte_r == fdw_pkg::CMD_SLEEP && hi_cnt_r >= SLEEP_MIN &&
        hi_cnt_r <= SLEEP_MIN + SLACK) else $error("sleep entry timing");
    a_sleep_deaf: assert property (in_deep_sleep |-> !accepting &&
        !$rose(status_byte[0])) else $error("accepting while asleep");
    a_powerup_standby: assert property (
        $rose(rst_n) |-> !in_deep_sleep [*8]) else $error("asleep at start");
    a_holdoff_quiet: assert property (
        up_cnt_r < int'(POWERUP_CYCLES) |-> !accepting)
        else $error("accepting during hold-off");
    a_wake_delay: assert property (
        $rose(accepting) && slept_r && first_byte_r == fdw_pkg::CMD_WAKE |->
        hi_cnt_r >= WAKE_MIN && hi_cnt_r <= WAKE_MIN + SLACK)
        else $error("wake delay wrong");
    a_id_start: assert property ($rose(miso_oe) |->
        bit_cnt_r == 6'h20 && first_byte_r == fdw_pkg::CMD_WAKE)
        else $error("id output started wrongly");
    a_busy_quiet: assert property (status_byte[0] |-> !miso_oe)
        else $error("output driven while busy");
    a_oe_released: assert property (cs_n [*8] |-> !miso_oe)
        else $error("output driven while deselected");
    a_flag_length: assert property ($fell(status_byte[0]) |->
        busy_cnt_r >= int'(CYCLE_CYCLES) - 2 &&
        busy_cnt_r <= int'(CYCLE_CYCLES) + 2) else $error("busy length wrong");
    a_delivered_state: assert property (
        status_byte[7:1] == 7'h00 && array_fill == fdw_pkg::ERASED_BYTE)
        else $error("delivered contents wrong");
endmodule : fdw_monitor

/* bench/tb.sv */
// Testbench joining host and flash ends through the serial link.
`timescale 1ns/1ps
module tb;
    localparam int unsigned PWR = 20;
    localparam int unsigned BUSY = 3000;
    localparam logic [7:0] DEV_ID = 8'h3c; // Arbitrary value.
    localparam int LIM = 6000;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_valid = 1'b0;
    fdw_pkg::fdw_op_type cmd_op = fdw_pkg::OP_SLEEP;
    logic [23:0] cmd_addr = 24'h000000;
    logic cmd_ready;
    logic done;
    logic id_valid;
    logic id_seen;
    logic [7:0] id_byte;
    logic [7:0] status_byte;
    logic [7:0] array_fill;
    logic in_deep_sleep;
    logic accepting;
    int fails = 0;
    int n_checks = 0;

    fdw_link_if u_fdw_link_if();
    fdw_host #(.POWERUP_CYCLES(PWR)) u_fdw_host (.ref_clk(ref_clk),
        .rst_n(rst_n), .link(u_fdw_link_if), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_ready(cmd_ready),
        .done(done), .id_byte(id_byte), .id_valid(id_valid));
    fdw_device #(.DEVICE_ID(DEV_ID), .POWERUP_CYCLES(PWR),
        .CYCLE_CYCLES(BUSY)) u_fdw_device (.ref_clk(ref_clk), .rst_n(rst_n),
        .link(u_fdw_link_if), .status_byte(status_byte),
        .in_deep_sleep(in_deep_sleep), .accepting(accepting),
        .array_fill(array_fill));
    fdw_monitor #(.POWERUP_CYCLES(PWR), .CYCLE_CYCLES(BUSY)) u_fdw_monitor (
        .ref_clk(ref_clk), .rst_n(rst_n), .cs_n(u_fdw_link_if.cs_n),
        .sclk(u_fdw_link_if.sclk), .mosi(u_fdw_link_if.mosi),
        .miso_oe(u_fdw_link_if.miso_oe), .status_byte(status_byte),
        .in_deep_sleep(in_deep_sleep), .accepting(accepting),
        .array_fill(array_fill));

    always #2 ref_clk = ~ref_clk;

    // ==========================================================
    // Tasks
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            $display("mismatch %s expected %h seen %h", what, exp, seen);
            fails++;
        end
    endtask : check

    // Waits are bounded so that a stuck handshake ends the run.
    // Ready and done are looked at between edges, where they have settled.
    task automatic run_op(input fdw_pkg::fdw_op_type op,
                          input logic [23:0] addr);
        int n;
        n = 0;
        id_seen = 1'b0;
        @(negedge ref_clk);
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_addr = addr;
        while (cmd_ready !== 1'b1 && n < LIM) begin
            @(negedge ref_clk);
            n++;
        end
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        while (done !== 1'b1 && n < LIM) begin
            @(negedge ref_clk);
            n++;
        end
        id_seen = id_valid;
        if (done !== 1'b1) begin
            fails++;
            wrap_up();
        end
    endtask : run_op

    task automatic power_up();
        rst_n = 1'b0;
        repeat (10) @(negedge ref_clk);
        rst_n = 1'b1;
        @(negedge ref_clk);
    endtask : power_up

    // ==========================================================
    // Scenarios
    initial begin
        power_up();
        check("accepting", {7'h00, accepting}, 8'h00);
        check("status", status_byte, fdw_pkg::STATUS_RESET);
        check("array", array_fill, fdw_pkg::ERASED_BYTE);
        check("asleep", {7'h00, in_deep_sleep}, 8'h00);
        run_op(fdw_pkg::OP_WAKE_ID, 24'h000000);
        check("id", id_byte, DEV_ID);
        check("id_valid", {7'h00, id_seen}, 8'h01);
        run_op(fdw_pkg::OP_SLEEP, 24'h000000);
        check("asleep", {7'h00, in_deep_sleep}, 8'h01);
        run_op(fdw_pkg::OP_ERASE, 24'h001000);
        check("status", status_byte, 8'h00);
        run_op(fdw_pkg::OP_WAKE, 24'h000000);
        check("asleep", {7'h00, in_deep_sleep}, 8'h00);
        check("accepting", {7'h00, accepting}, 8'h01);
        run_op(fdw_pkg::OP_SLEEP, 24'h000000);
        run_op(fdw_pkg::OP_WAKE_ID, 24'h000000);
        check("id", id_byte, DEV_ID);
        check("asleep", {7'h00, in_deep_sleep}, 8'h00);
        run_op(fdw_pkg::OP_ERASE, 24'h002000);
        repeat (4) @(negedge ref_clk);
        check("status", status_byte, 8'h01);
        run_op(fdw_pkg::OP_SLEEP, 24'h000000);
        check("asleep", {7'h00, in_deep_sleep}, 8'h00);
        check("status", status_byte, 8'h01);
        run_op(fdw_pkg::OP_WAKE_ID, 24'h000000);
        check("id", id_byte, 8'hff);
        check("status", status_byte, 8'h01);
        for (int n = 0; n < LIM && status_byte !== 8'h00; n++) begin
            @(negedge ref_clk);
        end
        if (status_byte !== 8'h00) begin
            fails++;
            wrap_up();
        end
        check("status", status_byte, 8'h00);
        check("accepting", {7'h00, accepting}, 8'h01);
        check("asleep", {7'h00, in_deep_sleep}, 8'h00);
        run_op(fdw_pkg::OP_SLEEP, 24'h000000);
        run_op(fdw_pkg::OP_RESET, 24'h000000);
        check("asleep", {7'h00, in_deep_sleep}, 8'h00);
        run_op(fdw_pkg::OP_WAKE_ID, 24'h000000);
        check("id", id_byte, DEV_ID);
        run_op(fdw_pkg::OP_SLEEP, 24'h000000);
        power_up();
        check("asleep", {7'h00, in_deep_sleep}, 8'h00);
        run_op(fdw_pkg::OP_WAKE_ID, 24'h000000);
        check("id", id_byte, DEV_ID);
        wrap_up();
    end
endmodule : tb

/* hdl/fdw_device.sv */
// Flash end: sleep, wake and identify handling with power-up hold-off.
`timescale 1ns/1ps
module fdw_device #(
    parameter logic [7:0] DEVICE_ID = 8'h5a, // Arbitrary value.
    parameter int unsigned POWERUP_CYCLES = fdw_pkg::POWERUP_CYC,
    parameter int unsigned CYCLE_CYCLES = fdw_pkg::CYCLE_TIME_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    fdw_link_if.dev link,
    output logic [7:0] status_byte,
    output logic in_deep_sleep,
    output logic accepting,
    output logic [7:0] array_fill
);
    // ==========================================================
    // Parameter checks
    if (POWERUP_CYCLES < 1 || CYCLE_CYCLES < 1) begin : g_bad_count
        $error("POWERUP_CYCLES and CYCLE_CYCLES must be at least 1");
    end

    typedef enum logic [4:0] {
        D_HOLD = 5'h01,
        D_STBY = 5'h02,
        D_ENTER = 5'h04,
        D_SLEEP = 5'h08,
        D_WAKE = 5'h10
    } fdw_dst_type;

    // ==========================================================
    // Pin filters
    // Three stages per pin; a change counts when stages two and three
    // agree, which also rejects a one-cycle glitch.
    wire [2:0] pin_w = {link.cs_n, link.sclk, link.mosi};
    logic [2:0] s1_r;
    logic [2:0] s2_r;
    logic [2:0] s3_r;
    logic [2:0] flt_r;
    logic [2:0] flt_d_r;

    for (genvar i = 0; i < 3; i++) begin : g_sync
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                s1_r[i] <= fdw_pkg::PIN_IDLE[i];
                s2_r[i] <= fdw_pkg::PIN_IDLE[i];
                s3_r[i] <= fdw_pkg::PIN_IDLE[i];
                flt_r[i] <= fdw_pkg::PIN_IDLE[i];
                flt_d_r[i] <= fdw_pkg::PIN_IDLE[i];
            end else begin
                s1_r[i] <= pin_w[i];
                s2_r[i] <= s1_r[i];
                s3_r[i] <= s2_r[i];
                if (s2_r[i] == s3_r[i]) begin
                    flt_r[i] <= s3_r[i];
                end
                flt_d_r[i] <= flt_r[i];
            end
        end
    end

    wire cs_rise = flt_r[2] && !flt_d_r[2];
    wire cs_fall = !flt_r[2] && flt_d_r[2];
    wire sclk_rise = flt_r[1] && !flt_d_r[1] && !flt_r[2];
    wire sclk_fall = !flt_r[1] && flt_d_r[1] && !flt_r[2];

    // ==========================================================
    // Frame state
    fdw_dst_type st_r;
    fdw_dst_type st_nxt;
    logic [31:0] cnt_r;
    logic [31:0] wake_len_r;
    logic [31:0] cyc_cnt_r;
    logic [5:0] bits_r;
    logic [7:0] sh_r;
    logic [7:0] cmd_r;
    logic frame_ok_r;
    logic rst_en_r;
    logic [7:0] status_r;
    logic miso_r;
    logic oe_r;

    wire busy = status_r[fdw_pkg::STS_CYCLE_BIT];
    wire [7:0] sh_nxt = {sh_r[6:0], flt_r[0]};
    wire take = cs_rise && frame_ok_r;
    wire len_cmd = bits_r == fdw_pkg::BITS_CMD;
    wire whole_bytes = bits_r[2:0] == 3'h0 && bits_r != 6'h0;
    wire listen = st_r == D_STBY || st_r == D_SLEEP;
    wire sleep_go = take && st_r == D_STBY && len_cmd &&
        cmd_r == fdw_pkg::CMD_SLEEP && !busy;
    wire wake_go = take && st_r == D_SLEEP && whole_bytes &&
        cmd_r == fdw_pkg::CMD_WAKE && !busy;
    wire rst_en_go = take && len_cmd && cmd_r == fdw_pkg::CMD_RST_EN;
    wire soft_rst = take && len_cmd && cmd_r == fdw_pkg::CMD_RST &&
        rst_en_r;
    wire cycle_go = take && st_r == D_STBY && whole_bytes &&
        fdw_pkg::fdw_is_write(cmd_r) && !busy;
    wire cycle_done = busy && cyc_cnt_r == 32'(CYCLE_CYCLES - 1);
    wire id_phase = !flt_r[2] && frame_ok_r && !busy &&
        cmd_r == fdw_pkg::CMD_WAKE && bits_r >= fdw_pkg::BITS_ID_START;
    wire [2:0] id_idx = 3'h7 - bits_r[2:0];

    // ==========================================================
    // Power-state sequencing
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            D_HOLD: begin
                if (cnt_r == 32'(POWERUP_CYCLES - 1)) begin
                    st_nxt = D_STBY;
                end
            end
            D_STBY: begin
                if (sleep_go) begin
                    st_nxt = D_ENTER;
                end
            end
            D_ENTER: begin
                if (cnt_r == 32'(fdw_pkg::SLEEP_ENTRY_CYC - 1)) begin
                    st_nxt = D_SLEEP;
                end
            end
            D_SLEEP: begin
                if (wake_go) begin
                    st_nxt = D_WAKE;
                end
            end
            D_WAKE: begin
                if (cnt_r == wake_len_r) begin
                    st_nxt = D_STBY;
                end
            end
        endcase
        if (soft_rst) begin
            st_nxt = D_STBY;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= D_HOLD;
            cnt_r <= 32'h0;
            wake_len_r <= 32'h0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= (st_nxt != st_r) ? 32'h0 : cnt_r + 32'h1;
            if (wake_go) begin
                wake_len_r <= len_cmd ? 32'(fdw_pkg::WAKE_CYC - 1) :
                    32'(fdw_pkg::WAKE_ID_CYC - 1);
            end
        end
    end

    // ==========================================================
    // Serial receive
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bits_r <= 6'h0;
            sh_r <= 8'h0;
            cmd_r <= 8'h0;
            frame_ok_r <= 1'b0;
            rst_en_r <= 1'b0;
        end else begin
            if (cs_fall) begin
                bits_r <= 6'h0;
                // Frames opened while held off or waking are ignored.
                frame_ok_r <= listen;
            end else if (sclk_rise) begin
                sh_r <= sh_nxt;
                if (bits_r != fdw_pkg::BITS_MAX) begin
                    bits_r <= bits_r + 6'h1;
                end
                if (bits_r == fdw_pkg::BITS_CMD - 6'h1) begin
                    cmd_r <= sh_nxt;
                end
            end
            if (take) begin
                rst_en_r <= rst_en_go && listen;
            end
        end
    end

    // ==========================================================
    // Self-timed cycle and status
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_r <= fdw_pkg::STATUS_RESET;
            cyc_cnt_r <= 32'h0;
        end else if (soft_rst || cycle_done) begin
            status_r[fdw_pkg::STS_CYCLE_BIT] <= 1'b0;
            cyc_cnt_r <= 32'h0;
        end else if (cycle_go) begin
            status_r[fdw_pkg::STS_CYCLE_BIT] <= 1'b1;
            cyc_cnt_r <= 32'h0;
        end else if (busy) begin
            cyc_cnt_r <= cyc_cnt_r + 32'h1;
        end
    end

    // ==========================================================
    // Identification output
    // Data changes on the falling clock so the host samples a settled bit.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            miso_r <= 1'b0;
            oe_r <= 1'b0;
        end else if (flt_r[2]) begin
            oe_r <= 1'b0;
        end else if (sclk_fall) begin
            miso_r <= DEVICE_ID[id_idx];
            oe_r <= id_phase;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_byte <= fdw_pkg::STATUS_RESET;
            in_deep_sleep <= 1'b0;
            accepting <= 1'b0;
            array_fill <= fdw_pkg::ERASED_BYTE;
        end else begin
            status_byte <= status_r;
            in_deep_sleep <= st_r == D_SLEEP;
            accepting <= st_r == D_STBY;
            array_fill <= fdw_pkg::ERASED_BYTE;
        end
    end

    assign link.miso = miso_r;
    assign link.miso_oe = oe_r;
endmodule : fdw_device

/* hdl/fdw_host.sv */
// Host end: issues sleep, wake, identify, reset and erase frames.
`timescale 1ns/1ps
module fdw_host #(
    parameter int unsigned POWERUP_CYCLES = fdw_pkg::POWERUP_CYC,
    parameter int unsigned SCLK_HALF = fdw_pkg::SCLK_HALF_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    fdw_link_if.host link,
    input wire logic cmd_valid,
    input wire fdw_pkg::fdw_op_type cmd_op,
    input wire logic [23:0] cmd_addr,
    output logic cmd_ready,
    output logic done,
    output logic [7:0] id_byte,
    output logic id_valid
);
    // ==========================================================
    // Parameter checks
    // The device needs several clocks per half bit to filter the pins.
    if (SCLK_HALF < 6) begin : g_bad_half
        $error("SCLK_HALF must be at least 6");
    end
    if (POWERUP_CYCLES < 1) begin : g_bad_pwr
        $error("POWERUP_CYCLES must be at least 1");
    end

    typedef enum logic [4:0] {
        H_POWER = 5'h01,
        H_IDLE = 5'h02,
        H_LOW = 5'h04,
        H_HIGH = 5'h08,
        H_GAP = 5'h10
    } fdw_hst_type;

    fdw_hst_type st_r;
    logic [31:0] cnt_r;
    logic [31:0] gap_r;
    logic [39:0] tx_r;
    logic [5:0] nbits_r;
    logic [5:0] bit_r;
    logic [7:0] rx_r;
    logic second_r;
    logic asleep_r;
    fdw_pkg::fdw_op_type op_r;
    logic cs_n_r;
    logic sclk_r;
    logic mosi_r;

    // ==========================================================
    // Frame build and timing decode
    wire take = (st_r == H_IDLE) && cmd_valid;
    wire half_end = cnt_r == 32'(SCLK_HALF - 1);
    wire gap_end = cnt_r == gap_r;
    wire [39:0] frame_w =
        cmd_op == fdw_pkg::OP_SLEEP ? {fdw_pkg::CMD_SLEEP, 32'h0} :
        cmd_op == fdw_pkg::OP_RESET ? {fdw_pkg::CMD_RST_EN, 32'h0} :
        cmd_op == fdw_pkg::OP_ERASE ?
            {fdw_pkg::CMD_SECT_ERASE, cmd_addr, 8'h0} :
        {fdw_pkg::CMD_WAKE, 32'h0};
    wire [5:0] nbits_w =
        cmd_op == fdw_pkg::OP_WAKE_ID ? fdw_pkg::BITS_ID_END :
        cmd_op == fdw_pkg::OP_ERASE ? fdw_pkg::BITS_ERASE :
        fdw_pkg::BITS_CMD;
    // Hold-off after each frame; wake waits also cover the pin filter.
    wire [31:0] gap_w =
        op_r == fdw_pkg::OP_SLEEP ?
            32'(fdw_pkg::SLEEP_ENTRY_CYC + fdw_pkg::GAP_CYC) :
        op_r == fdw_pkg::OP_WAKE ?
            32'(fdw_pkg::WAKE_CYC + fdw_pkg::GAP_CYC) :
        op_r == fdw_pkg::OP_WAKE_ID && asleep_r ?
            32'(fdw_pkg::WAKE_ID_CYC + fdw_pkg::GAP_CYC) :
        32'(fdw_pkg::GAP_CYC);
    wire last_bit = bit_r == nbits_r;

    // ==========================================================
    // Sequencer
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= H_POWER;
            cnt_r <= 32'h0;
            gap_r <= 32'h0;
            tx_r <= 40'h0;
            nbits_r <= 6'h0;
            bit_r <= 6'h0;
            rx_r <= 8'h0;
            second_r <= 1'b0;
            asleep_r <= 1'b0;
            op_r <= fdw_pkg::OP_SLEEP;
            cs_n_r <= 1'b1;
            sclk_r <= 1'b0;
            mosi_r <= 1'b0;
            cmd_ready <= 1'b0;
            done <= 1'b0;
            id_byte <= 8'h0;
            id_valid <= 1'b0;
        end else begin
            done <= 1'b0;
            id_valid <= 1'b0;
            cnt_r <= cnt_r + 32'h1;
            unique case (st_r)
                H_POWER: begin
                    if (cnt_r == 32'(POWERUP_CYCLES - 1)) begin
                        st_r <= H_IDLE;
                        cmd_ready <= 1'b1;
                    end
                end
                H_IDLE: begin
                    if (take) begin
                        st_r <= H_LOW;
                        cmd_ready <= 1'b0;
                        op_r <= cmd_op;
                        second_r <= cmd_op == fdw_pkg::OP_RESET;
                        tx_r <= frame_w;
                        nbits_r <= nbits_w;
                        bit_r <= 6'h0;
                        cs_n_r <= 1'b0;
                        mosi_r <= frame_w[39];
                        cnt_r <= 32'h0;
                    end
                end
                H_LOW: begin
                    if (half_end) begin
                        cnt_r <= 32'h0;
                        if (last_bit) begin
                            cs_n_r <= 1'b1;
                            st_r <= H_GAP;
                            gap_r <= gap_w;
                        end else begin
                            sclk_r <= 1'b1;
                            st_r <= H_HIGH;
                        end
                    end
                end
                H_HIGH: begin
                    if (half_end) begin
                        cnt_r <= 32'h0;
                        sclk_r <= 1'b0;
                        rx_r <= {rx_r[6:0], link.miso_line};
                        tx_r <= {tx_r[38:0], 1'b0};
                        mosi_r <= tx_r[38];
                        bit_r <= bit_r + 6'h1;
                        st_r <= H_LOW;
                    end
                end
                H_GAP: begin
                    if (gap_end && second_r) begin
                        second_r <= 1'b0;
                        tx_r <= {fdw_pkg::CMD_RST, 32'h0};
                        mosi_r <= fdw_pkg::CMD_RST[7];
                        bit_r <= 6'h0;
                        cs_n_r <= 1'b0;
                        cnt_r <= 32'h0;
                        st_r <= H_LOW;
                    end else if (gap_end) begin
                        st_r <= H_IDLE;
                        cmd_ready <= 1'b1;
                        done <= 1'b1;
                        asleep_r <= op_r == fdw_pkg::OP_SLEEP ||
                            (asleep_r && op_r == fdw_pkg::OP_ERASE);
                        if (op_r == fdw_pkg::OP_WAKE_ID) begin
                            id_byte <= rx_r;
                            id_valid <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    assign link.cs_n = cs_n_r;
    assign link.sclk = sclk_r;
    assign link.mosi = mosi_r;
endmodule : fdw_host

/* hdl/fdw_link_if.sv */
// Serial link between the host controller and the flash power-state end.
`timescale 1ns/1ps
interface fdw_link_if;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic miso_line;

    // The released data line is pulled high.
    assign miso_line = miso_oe ? miso : 1'b1;

    modport dev (
        input cs_n,
        input sclk,
        input mosi,
        output miso,
        output miso_oe
    );

    modport host (
        output cs_n,
        output sclk,
        output mosi,
        input miso_line
    );
endinterface : fdw_link_if

/* hdl/fdw_pkg.sv */
// Constants and types shared by both ends of the flash power-state link.
package fdw_pkg;

    // ==========================================================
    // Clock and timing
    localparam int REF_CLK_MHZ = 250;
    localparam int NS_PER_US = 1000;
    localparam int SLEEP_ENTRY_NS = 3000;
    localparam int WAKE_NS = 3000;
    localparam int WAKE_ID_NS = 3000;
    localparam int POWERUP_MS = 1;
    // Least times round up to whole cycles.
    localparam int SLEEP_ENTRY_CYC =
        (SLEEP_ENTRY_NS * REF_CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
    localparam int WAKE_CYC = (WAKE_NS * REF_CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
    localparam int WAKE_ID_CYC =
        (WAKE_ID_NS * REF_CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
    localparam int POWERUP_CYC = POWERUP_MS * NS_PER_US * REF_CLK_MHZ;
    localparam int CYCLE_TIME_CYC = 1000;
    localparam int GAP_CYC = 8;
    localparam int SCLK_HALF_CYC = 8;

    // ==========================================================
    // Command codes and frame layout
    localparam logic [7:0] CMD_SLEEP = 8'hb9;
    localparam logic [7:0] CMD_WAKE = 8'hab;
    localparam logic [7:0] CMD_RST_EN = 8'h66;
    localparam logic [7:0] CMD_RST = 8'h99;
    localparam logic [7:0] CMD_SECT_ERASE = 8'h20;
    localparam logic [7:0] CMD_BLK32_ERASE = 8'h52;
    localparam logic [7:0] CMD_BLK64_ERASE = 8'hd8;
    localparam logic [7:0] CMD_CHIP_ERASE_A = 8'h60;
    localparam logic [7:0] CMD_CHIP_ERASE_B = 8'hc7;
    localparam logic [7:0] CMD_PAGE_PROG = 8'h02;
    localparam logic [7:0] CMD_QUAD_PROG = 8'h32;
    localparam logic [7:0] CMD_STATUS_WR = 8'h01;
    localparam int BYTE_BITS = 8;
    localparam int ID_DUMMY_BYTES = 3;
    localparam int BIT_CNT_W = 6;
    localparam logic [5:0] BITS_CMD = 6'h08;
    localparam logic [5:0] BITS_ID_START = 6'h20;
    localparam logic [5:0] BITS_ERASE = 6'h20;
    localparam logic [5:0] BITS_ID_END = 6'h28;
    localparam logic [5:0] BITS_MAX = 6'h3f;

    // ==========================================================
    // Status and delivered contents
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam int STS_CYCLE_BIT = 0;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [2:0] PIN_IDLE = 3'h4;

    typedef enum logic [2:0] {
        OP_SLEEP = 3'h0,
        OP_WAKE = 3'h1,
        OP_WAKE_ID = 3'h2,
        OP_RESET = 3'h3,
        OP_ERASE = 3'h4
    } fdw_op_type;

    function automatic logic fdw_is_write(input logic [7:0] code);
        return code == CMD_SECT_ERASE || code == CMD_BLK32_ERASE ||
               code == CMD_BLK64_ERASE || code == CMD_CHIP_ERASE_A ||
               code == CMD_CHIP_ERASE_B || code == CMD_PAGE_PROG ||
               code == CMD_QUAD_PROG || code == CMD_STATUS_WR;
    endfunction : fdw_is_write

endpackage : fdw_pkg
